// >>> rtl/cstdpm_defs.svh
// Constants for the charge safety timer and input power management control block.
// Assumes a 10 MHz system clock and a byte-wide register write strobe from the I2C front end.
`ifndef CSTDPM_DEFS_SVH
`define CSTDPM_DEFS_SVH
`define CSTDPM_REG_RESET      8'h42
`define CSTDPM_DPM_DIS_BIT    7
`define CSTDPM_DPM_CODE_HI    6
`define CSTDPM_DPM_CODE_LO    4
`define CSTDPM_HALF_RATE_BIT  3
`define CSTDPM_LIMIT_HI       2
`define CSTDPM_LIMIT_LO       1
`define CSTDPM_RSVD_BIT       0
`define CSTDPM_DPM_BASE_MV    13'h1068
`define CSTDPM_DPM_STEP_MV    13'h0064
`define CSTDPM_CLK_HZ         10000000
`define CSTDPM_TICK_HZ        1
`define CSTDPM_TICK_DIV       (`CSTDPM_CLK_HZ / `CSTDPM_TICK_HZ)
`define CSTDPM_LIM_30M_MIN    30
`define CSTDPM_LIM_3H_MIN     180
`define CSTDPM_LIM_9H_MIN     540
`define CSTDPM_SEC_PER_MIN    60
`define CSTDPM_SEL_30M        2'h0
`define CSTDPM_SEL_3H         2'h1
`define CSTDPM_SEL_9H         2'h2
`define CSTDPM_SEL_OFF        2'h3
`endif

// >>> rtl/cstdpm_pkg.sv
// Types for the charge safety timer and input power management control block.
// Assumes the defines header is compiled with it.
package cstdpm_pkg;
  typedef enum logic [3:0]
  {
    CSTDPM_CTRL_IDLE = 4'h1,
    CSTDPM_CTRL_CC   = 4'h2,
    CSTDPM_CTRL_CV   = 4'h4,
    CSTDPM_CTRL_OTHER = 4'h8
  } cstdpm_ctrl_type;
  typedef enum logic [2:0]
  {
    CSTDPM_TMR_IDLE    = 3'h1,
    CSTDPM_TMR_RUN     = 3'h2,
    CSTDPM_TMR_EXPIRED = 3'h4
  } cstdpm_tmr_type;
endpackage

// >>> rtl/cstdpm_tick.sv
// Divider producing a one-cycle tick per second, halved in rate when asked.
// Assumes one sys_clk domain.
`timescale 1ns/1ps
`include "cstdpm_defs.svh"
module cstdpm_tick
(
  input  wire logic sys_clk,   // System clock
  input  wire logic rst_n,     // Synchronous reset, active low
  input  wire logic clear,     // Restart the divider
  input  wire logic half_rate, // Emit every second tick only
  output logic      tick       // One-cycle seconds pulse
);
  localparam logic [23:0] DIV_LAST = 24'(`CSTDPM_TICK_DIV - 1);
  logic [23:0] div_q;
  logic        skip_q;
  logic        wrap;
  assign wrap = (div_q == DIV_LAST);
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || clear)
      div_q <= 24'h000000;
    else if (wrap)
      div_q <= 24'h000000;
    else
      div_q <= div_q + 24'h000001;
  end
  // Half rate drops every other wrap so the count runs at half speed.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || clear)
      skip_q <= 1'b0;
    else if (wrap)
      skip_q <= half_rate ? ~skip_q : 1'b0;
  end
  assign tick = wrap && !(half_rate && skip_q);
endmodule

// >>> rtl/cstdpm_ctrl.sv
// Control register for input power management and the fast-charge safety timer.
// Assumes the I2C front end gives a one-cycle write strobe with byte data, and that
// the charger core reports its control state and charge-cycle start on sys_clk.
//
// Contract
// - Power management is active while the top bit is zero, off when one.
// - Half-rate bit slows the timer by two outside CC and CV only.
// - Limit field: 00 thirty minutes, 01 three hours, 10 nine hours, 11 off.
// - Register defaults apply from reset until the host writes new values.
`timescale 1ns/1ps
`include "cstdpm_defs.svh"
module cstdpm_ctrl
  import cstdpm_pkg::*;
(
  input  wire logic                  sys_clk,            // System clock, 10 MHz
  input  wire logic                  rst_n,              // Synchronous reset, active low
  input  wire logic                  reg_wr,             // Register write strobe
  input  wire logic [7:0]            reg_wdata,          // Register write data
  output logic      [7:0]            reg_rdata,          // Register read data
  input  wire logic                  charge_start,       // Pulse at start of a charge cycle
  input  wire logic                  fast_charge_req,    // Core wants to fast charge
  input  wire cstdpm_pkg::cstdpm_ctrl_type ctrl_state,   // Charger control state
  output logic                       input_dpm_enable,   // Input power management active
  output logic      [12:0]           input_voltage_regulation, // Threshold in mV
  output logic                       fast_charge_allow,  // Fast charge permitted
  output logic                       safety_timer_fault, // Timer has expired
  output logic                       timer_slowed        // Timer runs at half rate
);
  import cstdpm_pkg::*;

  logic [7:0]     ctrl_q;
  cstdpm_tmr_type tmr_q;
  logic [15:0]    secs_q;
  logic           tick;
  logic           restart;
  logic [1:0]     limit_sel;
  logic [2:0]     dpm_code;
  logic [15:0]    limit_secs;
  logic           half_rate_en;

  function automatic logic [15:0] limit_to_secs(input logic [1:0] sel);
    case (sel)
      `CSTDPM_SEL_30M: limit_to_secs = 16'(`CSTDPM_LIM_30M_MIN * `CSTDPM_SEC_PER_MIN);
      `CSTDPM_SEL_3H:  limit_to_secs = 16'(`CSTDPM_LIM_3H_MIN * `CSTDPM_SEC_PER_MIN);
      `CSTDPM_SEL_9H:  limit_to_secs = 16'(`CSTDPM_LIM_9H_MIN * `CSTDPM_SEC_PER_MIN);
      default:         limit_to_secs = 16'hFFFF;
    endcase
  endfunction

  // The reserved bit is stored as written but never read back, so it reads zero.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ctrl_q <= `CSTDPM_REG_RESET;
    else if (reg_wr)
      ctrl_q <= reg_wdata;
  end
  // Read data is taken straight from the stored byte, so a write shows on the very next cycle.
  assign reg_rdata = {ctrl_q[`CSTDPM_DPM_DIS_BIT:`CSTDPM_LIMIT_LO], 1'b0};

  assign limit_sel    = ctrl_q[`CSTDPM_LIMIT_HI:`CSTDPM_LIMIT_LO];
  assign dpm_code     = ctrl_q[`CSTDPM_DPM_CODE_HI:`CSTDPM_DPM_CODE_LO];
  assign half_rate_en = ctrl_q[`CSTDPM_HALF_RATE_BIT];
  assign limit_secs   = limit_to_secs(limit_sel);

  assign input_dpm_enable = !ctrl_q[`CSTDPM_DPM_DIS_BIT];
  assign input_voltage_regulation = `CSTDPM_DPM_BASE_MV + 13'(dpm_code) * `CSTDPM_DPM_STEP_MV;

  // Slowing applies only when enabled and the core is outside CC and CV.
  assign timer_slowed = half_rate_en && (ctrl_state != CSTDPM_CTRL_CC)
                        && (ctrl_state != CSTDPM_CTRL_CV);

  // Any register write restarts timing; a new charge cycle does too.
  assign restart = reg_wr || charge_start;

  cstdpm_tick u_tick
  (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clear     (restart),
    .half_rate (timer_slowed),
    .tick      (tick)
  );

  // The expired state is only left through reset or restart, so a fault cannot clear itself.
  // Restart and expiry in one cycle resolve to idle, which favours the host's intent.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || restart)
    begin
      tmr_q <= CSTDPM_TMR_IDLE;
    end
    else
    begin
      case (tmr_q)
        CSTDPM_TMR_IDLE:
        begin
          if (fast_charge_req && limit_sel != `CSTDPM_SEL_OFF)
            tmr_q <= CSTDPM_TMR_RUN;
        end
        CSTDPM_TMR_RUN:
        begin
          if (limit_sel == `CSTDPM_SEL_OFF)
            tmr_q <= CSTDPM_TMR_IDLE;
          else if (tick && secs_q + 16'h0001 >= limit_secs)
            tmr_q <= CSTDPM_TMR_EXPIRED;
        end
        CSTDPM_TMR_EXPIRED:
        begin
          tmr_q <= CSTDPM_TMR_EXPIRED;
        end
        default:
        begin
          tmr_q <= CSTDPM_TMR_IDLE;
        end
      endcase
    end
  end

  // Seconds count only while running; the limit compare sits in the state machine.
  // A sixteen-bit count covers the longest limit with room to spare.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || restart)
    begin
      secs_q <= 16'h0000;
    end
    else if (tmr_q == CSTDPM_TMR_RUN && tick)
    begin
      secs_q <= secs_q + 16'h0001;
    end
  end

  assign safety_timer_fault = (tmr_q == CSTDPM_TMR_EXPIRED);
  assign fast_charge_allow  = fast_charge_req && (tmr_q != CSTDPM_TMR_EXPIRED);
endmodule

// >>> dv/cstdpm_checker.sv
// Port assertions for the control register block.
// Assumes one sys_clk domain and a bind to cstdpm_ctrl.
`timescale 1ns/1ps
module cstdpm_checker
  import cstdpm_pkg::*;
(
  input wire logic                        sys_clk,                  // Clock
  input wire logic                        rst_n,                    // Reset
  input wire logic                        reg_wr,                   // Strobe
  input wire logic [7:0]                  reg_wdata,                // Data in
  input wire logic [7:0]                  reg_rdata,                // Data out
  input wire logic                        charge_start,             // New cycle
  input wire logic                        fast_charge_req,          // Request
  input wire cstdpm_pkg::cstdpm_ctrl_type ctrl_state,               // State
  input wire logic                        input_dpm_enable,         // Enable
  input wire logic [12:0]                 input_voltage_regulation, // mV
  input wire logic                        fast_charge_allow,        // Allow
  input wire logic                        safety_timer_fault,       // Fault
  input wire logic                        timer_slowed              // Slowed
);
  import cstdpm_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_write;
    reg_wr ##1 1'b1;
  endsequence
  a_dpm_follows: assert property (input_dpm_enable == !reg_rdata[7]) else $error("dpm enable wrong");
  a_thresh_code: assert property (input_voltage_regulation == 13'h1068 + 13'(reg_rdata[6:4]) * 13'h0064)
    else $error("threshold wrong");
  a_slow_state: assert property (timer_slowed == (reg_rdata[3] && ctrl_state != CSTDPM_CTRL_CC
    && ctrl_state != CSTDPM_CTRL_CV)) else $error("slowing wrong");
  a_write_lands: assert property (s_write |-> reg_rdata == {$past(reg_wdata[7:1]), 1'b0})
    else $error("write not stored");
  a_hold_value: assert property (!reg_wr |=> $stable(reg_rdata)) else $error("register changed");
  a_write_restart: assert property (s_write |-> !safety_timer_fault) else $error("fault after write");
  a_start_restart: assert property (charge_start |=> !safety_timer_fault) else $error("fault after start");
  a_allow_gate: assert property (fast_charge_allow == (fast_charge_req && !safety_timer_fault))
    else $error("allow wrong");
  a_off_never: assert property (reg_rdata[2:1] == 2'h3 && !safety_timer_fault |=> !safety_timer_fault)
    else $error("disabled timer expired");
endmodule
bind cstdpm_ctrl cstdpm_checker i_chk (.sys_clk, .rst_n, .reg_wr, .reg_wdata, .reg_rdata, .charge_start,
  .fast_charge_req, .ctrl_state, .input_dpm_enable, .input_voltage_regulation, .fast_charge_allow,
  .safety_timer_fault, .timer_slowed);

// >>> dv/cstdpm_host.sv
// Host model writing the register through the byte strobe.
// Assumes the write is taken on a rising edge of sys_clk.
`timescale 1ns/1ps
module cstdpm_host
(
  input  wire logic       sys_clk,  // Clock
  output logic            reg_wr,   // Strobe
  output logic      [7:0] reg_wdata // Data
);
  initial reg_wr = 1'b0;
  initial reg_wdata = 8'h00;
  // Released data is inverted so a stale byte never looks valid.
  task automatic wr(input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
endmodule

// >>> dv/test_charge_safety_timer_dpm_ctrl.sv
// Self-checking bench for the control register block.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
module test_charge_safety_timer_dpm_ctrl;
  import cstdpm_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, charge_start = 1'b0, fast_charge_req = 1'b0;
  cstdpm_ctrl_type ctrl_state = CSTDPM_CTRL_IDLE;
  logic reg_wr, input_dpm_enable, fast_charge_allow, safety_timer_fault, timer_slowed;
  logic [7:0] reg_wdata, reg_rdata;
  logic [12:0] input_voltage_regulation;
  int err_count = 0, n_checks = 0;
  always #50 sys_clk = ~sys_clk;
  cstdpm_host i_host (.sys_clk, .reg_wr, .reg_wdata);
  cstdpm_ctrl i_dut (.sys_clk, .rst_n, .reg_wr, .reg_wdata, .reg_rdata, .charge_start, .fast_charge_req,
    .ctrl_state, .input_dpm_enable, .input_voltage_regulation, .fast_charge_allow, .safety_timer_fault,
    .timer_slowed);
  task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    chk("rdata", 13'(reg_rdata), 13'h0042);
    chk("vreg", input_voltage_regulation, 13'h11F8);
    $display("test defaults done");
    for (int i = 0; i < 8; i++)
    begin
      i_host.wr({i[0], i[2:0], 4'hF});
      chk("rdata", 13'(reg_rdata), 13'({i[0], i[2:0], 4'hE}));
      chk("dpm", 13'(input_dpm_enable), 13'(!i[0]));
      chk("vreg", input_voltage_regulation, 13'h1068 + 13'(i) * 13'h0064);
    end
    $display("test codes done");
    for (int h = 0; h < 2; h++)
    begin
      i_host.wr(8'(h << 3));
      for (int s = 0; s < 4; s++)
      begin
        ctrl_state = cstdpm_ctrl_type'(4'h1 << s);
        @(negedge sys_clk);
        chk("slowed", 13'(timer_slowed), 13'(h == 1 && s != 1 && s != 2));
      end
    end
    $display("test slowing done");
    for (int k = 0; k < 4; k++)
    begin
      i_host.wr(8'(k << 1));
      fast_charge_req = 1'b1;
      charge_start = 1'b1;
      @(negedge sys_clk);
      charge_start = 1'b0;
      repeat (20) @(negedge sys_clk);
      chk("allow", 13'(fast_charge_allow), 13'h0001);
      chk("fault", 13'(safety_timer_fault), 13'h0000);
      fast_charge_req = 1'b0;
      @(negedge sys_clk);
      chk("allow", 13'(fast_charge_allow), 13'h0000);
    end
    $display("test limits done");
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    chk("rdata", 13'(reg_rdata), 13'h0042);
    $display("test reset done");
    results();
  end
endmodule
